// ### trc_pkg.sv
// package: register map, field layout and timing of the transceiver control
package trc_pkg;

  // register offsets
  localparam logic [7:0] CHIP_STATE_CONTROL_OFS = 8'h00;
  localparam logic [7:0] PROTOCOL_SELECT_OFS = 8'h01;
  localparam logic [7:0] TYPE_B_TRANSMIT_OPTIONS_OFS = 8'h02;
  localparam logic [7:0] TYPE_A_HIGH_RATE_OPTIONS_OFS = 8'h03;
  localparam logic [7:0] TRANSMIT_TIMER_HIGH_OFS = 8'h04;
  localparam logic [7:0] TRANSMIT_TIMER_LOW_OFS = 8'h05;
  localparam logic [7:0] TRANSMIT_PULSE_LENGTH_OFS = 8'h06;
  localparam logic [7:0] NO_RESPONSE_TIMEOUT_OFS = 8'h07;
  localparam logic [7:0] RECEIVE_WAIT_TIME_OFS = 8'h08;
  localparam logic [7:0] MODULATOR_CLOCK_OUTPUT_CONTROL_OFS = 8'h09;
  localparam logic [7:0] RECEIVE_SPECIAL_SETTING_OFS = 8'h0a;
  localparam logic [7:0] REGULATOR_IO_CONTROL_OFS = 8'h0b;
  localparam logic [7:0] INTERRUPT_STATUS_OFS = 8'h0c;
  localparam logic [7:0] COLLISION_AND_IRQ_MASK_OFS = 8'h0d;
  localparam logic [7:0] COLLISION_LOCATION_OFS = 8'h0e;
  localparam logic [7:0] SIGNAL_LEVEL_OSC_STATUS_OFS = 8'h0f;
  localparam logic [7:0] SPECIAL_FUNCTION_A_OFS = 8'h10;
  localparam logic [7:0] SPECIAL_FUNCTION_B_OFS = 8'h11;
  localparam logic [7:0] SCRATCH_BYTE_A_OFS = 8'h12;
  localparam logic [7:0] SCRATCH_BYTE_B_OFS = 8'h13;
  localparam logic [7:0] BUFFER_IRQ_LEVELS_OFS = 8'h14;
  localparam logic [7:0] RESERVED_15_OFS = 8'h15;
  localparam logic [7:0] LOW_FIELD_LEVEL_OFS = 8'h16;
  localparam logic [7:0] TARGET_IDENTIFIER_OFS = 8'h17;
  localparam logic [7:0] TARGET_DETECT_LEVEL_OFS = 8'h18;
  localparam logic [7:0] TARGET_PROTOCOL_OFS = 8'h19;
  localparam logic [7:0] FACTORY_CHECK_A_OFS = 8'h1a;
  localparam logic [7:0] FACTORY_CHECK_B_OFS = 8'h1b;
  localparam logic [7:0] BUFFER_STATUS_OFS = 8'h1c;
  localparam logic [7:0] TRANSMIT_LENGTH_FIRST_OFS = 8'h1d;
  localparam logic [7:0] TRANSMIT_LENGTH_SECOND_OFS = 8'h1e;
  localparam logic [7:0] BUFFER_DATA_PORT_OFS = 8'h1f;
  localparam logic [7:0] LAST_OFS = 8'h1f;
  localparam int unsigned NUM_REGS = 32;

  // chip state control fields
  localparam int unsigned STANDBY_BIT = 7;
  localparam int unsigned DIRECT_BIT = 6;
  localparam int unsigned FIELD_ENABLE_BIT = 5;
  localparam int unsigned DRIVE_STRENGTH_BIT = 4;
  localparam int unsigned RX_INPUT_SEL_BIT = 3;
  localparam int unsigned FORCED_RX_BIT = 1;
  localparam int unsigned SUPPLY_RANGE_BIT = 0;
  localparam logic [7:0] CHIP_STATE_WRITE_MASK = 8'hfb;
  // protocol select and modulator fields
  localparam int unsigned DIRECT_TYPE_BIT = 6;
  localparam logic [7:0] CLOCK_DIVIDER_MASK = 8'h30;
  // collision and mask register: position in 7:6, mask in 5:0
  localparam logic [7:0] COLLISION_HW_MASK = 8'hc0;
  localparam int unsigned TARGET_ID_BYTES = 10;

  // reset and protocol default values
  localparam logic [7:0] CHIP_STATE_RESET = 8'h01;
  localparam logic [7:0] PROTOCOL_SELECT_RESET = 8'h02;
  localparam logic [7:0] RECEIVE_SPECIAL_RESET = 8'h10;
  localparam logic [7:0] REGULATOR_IO_RESET = 8'h87;
  localparam logic [7:0] COLLISION_MASK_RESET = 8'h3e;
  localparam logic [7:0] ZERO_RESET = 8'h00;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STARTUP_TIME_NS = 100000;
  localparam int unsigned STARTUP_CYCLES =
    (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // control levels steering the front end
  typedef struct packed {
    logic standby;
    logic direct_mode_enable;
    logic direct_mode_one;
    logic transmitter_on;
    logic receiver_on;
    logic tx_oscillator_on;
    logic output_drive_strength_select;
    logic receive_input_select;
    logic supply_range_select;
  } trc_ctrl_type;

  // host register port request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } trc_req_type;

  // preset value of each register
  function automatic logic [7:0] reset_value(input logic [4:0] idx);
    logic [7:0] v;
    v = ZERO_RESET;
    unique case ({3'h0, idx})
      CHIP_STATE_CONTROL_OFS: v = CHIP_STATE_RESET;
      PROTOCOL_SELECT_OFS: v = PROTOCOL_SELECT_RESET;
      RECEIVE_SPECIAL_SETTING_OFS: v = RECEIVE_SPECIAL_RESET;
      REGULATOR_IO_CONTROL_OFS: v = REGULATOR_IO_RESET;
      COLLISION_AND_IRQ_MASK_OFS: v = COLLISION_MASK_RESET;
      default: v = ZERO_RESET;
    endcase
    return v;
  endfunction : reset_value

  // bits the host may write in each stored register
  function automatic logic [7:0] write_mask(input logic [4:0] idx);
    logic [7:0] m;
    m = 8'hff;
    unique case ({3'h0, idx})
      CHIP_STATE_CONTROL_OFS: m = CHIP_STATE_WRITE_MASK;
      INTERRUPT_STATUS_OFS,
      COLLISION_LOCATION_OFS,
      SIGNAL_LEVEL_OSC_STATUS_OFS,
      TARGET_IDENTIFIER_OFS,
      BUFFER_STATUS_OFS,
      BUFFER_DATA_PORT_OFS: m = 8'h00;
      default: m = 8'hff;
    endcase
    return m;
  endfunction : write_mask

endpackage : trc_pkg

// ### trc_register_map.sv
// transceiver control register map and chip state control logic
//
// Summary of operation
// - Standby bit set enters standby; cleared means active operation.
// - Direct bit set selects direct mode; cleared uses automatic framing.
// - Field enable on: transmitter and receivers on; off: transmitter off.
// - Drive strength bit: one is half power, zero is full power.
// - Receive input select: one picks auxiliary input, zero primary input.
// - Forced receiver bit enables receiver and transmit oscillator.
// - Lowest chip state bit selects five-volt (1) or three-volt (0) supply.
// - Target identifier is write-only, up to ten bytes, never read back.
// - Collision position shares a register with mask bits; host writes reach both, but only the mask bits in a cycle with a collision update.
// - Protocol selection write reloads option registers with defaults.
// - Clock divider bits keep their values across protocol selection.
// - Direct-mode type bit: cleared is direct mode 0, set is mode 1.
`timescale 1ns/1ns

module trc_register_map #(
  parameter int unsigned STARTUP_CYCLES = trc_pkg::STARTUP_CYCLES,
  parameter int unsigned ID_BYTES = trc_pkg::TARGET_ID_BYTES
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic enable_pin, // chip enable pin, asynchronous
  input wire trc_pkg::trc_req_type host_req, // host register request
  output logic [7:0] host_rdata, // read data
  output logic host_rvalid, // read data valid pulse
  input wire logic [7:0] irq_status_in, // interrupt status from core
  input wire logic collision_update, // load collision position pulse
  input wire logic [1:0] collision_high_in, // collision position high bits
  input wire logic [7:0] collision_location_in, // remaining collision bits
  input wire logic [7:0] signal_level_in, // signal level and osc status
  input wire logic [7:0] buffer_status_in, // buffer status from core
  input wire logic [7:0] buffer_rdata_in, // buffer read data
  output trc_pkg::trc_ctrl_type ctrl, // front end control levels
  output logic full_operation, // start-up interval elapsed
  output logic [10:0][7:0] config_out, // protocol and option bytes
  output logic [5:0] irq_mask_out, // interrupt mask bits
  output logic [ID_BYTES-1:0][7:0] target_id_out, // target identifier
  output logic buffer_wr, // buffer write pulse
  output logic buffer_rd, // buffer read pulse
  output logic [7:0] buffer_wdata // buffer write data
);

  localparam int unsigned CNT_W = $clog2(STARTUP_CYCLES + 1);
  localparam int unsigned IDX_W = $clog2(ID_BYTES + 1);

  logic en_meta_r;
  logic en_sync_r;
  logic preset;
  logic [7:0] regs_r [trc_pkg::NUM_REGS];
  logic mapped;
  logic [4:0] idx;
  logic wr_hit;
  logic proto_reload;
  logic [7:0] rdata_nxt;
  logic [IDX_W-1:0] id_idx_r;
  logic [CNT_W-1:0] start_cnt_r;
  trc_pkg::trc_ctrl_type ctrl_r;
  trc_pkg::trc_ctrl_type ctrl_nxt;
  logic full_op_r;
  logic rvalid_r;
  logic [7:0] rdata_r;
  logic buf_wr_r;
  logic buf_rd_r;
  logic [7:0] buf_wdata_r;
  logic [ID_BYTES-1:0][7:0] id_r;

  // enable pin crosses in through two flops before any use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
    end else begin
      en_meta_r <= enable_pin;
      en_sync_r <= en_meta_r;
    end
  end

  // pin held low presets the whole map, like power-on
  assign preset = ~en_sync_r;

  // address decode; everything above the map is unmapped
  assign mapped = (host_req.addr <= trc_pkg::LAST_OFS);
  assign idx = host_req.addr[4:0];
  assign wr_hit = host_req.wr & mapped;
  assign proto_reload = wr_hit &
    (host_req.addr == trc_pkg::PROTOCOL_SELECT_OFS);

  // one flop array entry per register, each with its own update logic
  for (genvar i = 0; i < trc_pkg::NUM_REGS; i++) begin : g_reg
    localparam logic [4:0] IDX = 5'(i);
    localparam logic [7:0] OFS = {3'h0, IDX};
    localparam logic [7:0] RST = trc_pkg::reset_value(IDX);
    localparam logic [7:0] WMASK = trc_pkg::write_mask(IDX);
    localparam bit IS_OPTION =
      (OFS >= trc_pkg::TYPE_B_TRANSMIT_OPTIONS_OFS) &&
      (OFS <= trc_pkg::REGULATOR_IO_CONTROL_OFS);
    localparam bit IS_CLKDIV =
      (OFS == trc_pkg::MODULATOR_CLOCK_OUTPUT_CONTROL_OFS);
    localparam bit IS_COLL =
      (OFS == trc_pkg::COLLISION_AND_IRQ_MASK_OFS);
    logic [7:0] wval;
    logic [7:0] rval;

    // host write merges only writable bits; reserved ones stay at preset
    assign wval = (host_req.wdata & WMASK) | (regs_r[i] & ~WMASK);
    // protocol defaults, but the clock divider bits survive the reload
    assign rval = IS_CLKDIV ?
      ((RST & ~trc_pkg::CLOCK_DIVIDER_MASK) |
       (regs_r[i] & trc_pkg::CLOCK_DIVIDER_MASK)) : RST;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        regs_r[i] <= RST;
      end else if (preset) begin
        regs_r[i] <= RST;
      end else if (IS_OPTION && proto_reload) begin
        regs_r[i] <= rval;
      end else if (IS_COLL && collision_update) begin
        // a fresh collision position wins over a host write in the same cycle; mask bits still take the write
        regs_r[i] <= {collision_high_in, regs_r[i][5:0]};
        if (wr_hit && idx == IDX) begin
          regs_r[i][5:0] <= host_req.wdata[5:0];
        end
      end else if (wr_hit && idx == IDX) begin
        regs_r[i] <= wval;
      end
    end
  end

  // target identifier bytes fill in order; any other access rewinds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      id_idx_r <= '0;
    end else if (preset) begin
      id_idx_r <= '0;
    end else if (wr_hit &&
                 host_req.addr == trc_pkg::TARGET_IDENTIFIER_OFS) begin
      if (id_idx_r != IDX_W'(ID_BYTES)) begin
        id_idx_r <= id_idx_r + 1'b1;
      end
    end else if (host_req.wr || host_req.rd) begin
      id_idx_r <= '0;
    end
  end

  // identifier storage; bytes past the tenth are dropped
  for (genvar b = 0; b < ID_BYTES; b++) begin : g_id
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        id_r[b] <= trc_pkg::ZERO_RESET;
      end else if (preset) begin
        id_r[b] <= trc_pkg::ZERO_RESET;
      end else if (wr_hit &&
                   host_req.addr == trc_pkg::TARGET_IDENTIFIER_OFS &&
                   id_idx_r == IDX_W'(b)) begin
        id_r[b] <= host_req.wdata;
      end
    end
  end

  // read mux: live status for read-only registers, zero where hidden
  always_comb begin
    rdata_nxt = 8'h00;
    if (mapped) begin
      unique case (host_req.addr)
        trc_pkg::INTERRUPT_STATUS_OFS: rdata_nxt = irq_status_in;
        trc_pkg::COLLISION_LOCATION_OFS:
          rdata_nxt = collision_location_in;
        trc_pkg::SIGNAL_LEVEL_OSC_STATUS_OFS: rdata_nxt = signal_level_in;
        trc_pkg::TARGET_IDENTIFIER_OFS: rdata_nxt = 8'h00;
        trc_pkg::BUFFER_STATUS_OFS: rdata_nxt = buffer_status_in;
        trc_pkg::BUFFER_DATA_PORT_OFS: rdata_nxt = buffer_rdata_in;
        default: rdata_nxt = regs_r[idx];
      endcase
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= host_req.rd & ~host_req.wr;
      if (host_req.rd && !host_req.wr) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // buffer data port passes straight through as strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_wr_r <= 1'b0;
      buf_rd_r <= 1'b0;
      buf_wdata_r <= 8'h00;
    end else begin
      buf_wr_r <= wr_hit &&
        host_req.addr == trc_pkg::BUFFER_DATA_PORT_OFS;
      buf_rd_r <= host_req.rd && !host_req.wr &&
        host_req.addr == trc_pkg::BUFFER_DATA_PORT_OFS;
      if (wr_hit && host_req.addr == trc_pkg::BUFFER_DATA_PORT_OFS) begin
        buf_wdata_r <= host_req.wdata;
      end
    end
  end

  // decode chip state control into front end levels
  always_comb begin
    logic [7:0] cs;
    cs = regs_r[trc_pkg::CHIP_STATE_CONTROL_OFS[4:0]];
    ctrl_nxt.standby = cs[trc_pkg::STANDBY_BIT];
    ctrl_nxt.direct_mode_enable = cs[trc_pkg::DIRECT_BIT];
    // type bit only matters while direct mode is entered
    ctrl_nxt.direct_mode_one = cs[trc_pkg::DIRECT_BIT] &
      regs_r[trc_pkg::PROTOCOL_SELECT_OFS[4:0]]
        [trc_pkg::DIRECT_TYPE_BIT];
    ctrl_nxt.transmitter_on = cs[trc_pkg::FIELD_ENABLE_BIT];
    ctrl_nxt.receiver_on = cs[trc_pkg::FIELD_ENABLE_BIT] |
      cs[trc_pkg::FORCED_RX_BIT];
    ctrl_nxt.tx_oscillator_on = cs[trc_pkg::FIELD_ENABLE_BIT] |
      cs[trc_pkg::FORCED_RX_BIT];
    ctrl_nxt.output_drive_strength_select =
      cs[trc_pkg::DRIVE_STRENGTH_BIT];
    ctrl_nxt.receive_input_select = cs[trc_pkg::RX_INPUT_SEL_BIT];
    ctrl_nxt.supply_range_select = cs[trc_pkg::SUPPLY_RANGE_BIT];
  end

  // registered so the analog side never sees decode glitches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // start-up timer after leaving standby; host should watch this flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_cnt_r <= '0;
      full_op_r <= 1'b0;
    end else if (ctrl_r.standby || preset) begin
      start_cnt_r <= '0;
      full_op_r <= 1'b0;
    end else if (start_cnt_r != CNT_W'(STARTUP_CYCLES)) begin
      start_cnt_r <= start_cnt_r + 1'b1;
      full_op_r <= 1'b0;
    end else begin
      full_op_r <= 1'b1;
    end
  end

  // outputs, all from flops
  for (genvar c = 0; c < 11; c++) begin : g_cfg
    assign config_out[c] = regs_r[c + 1];
  end
  assign irq_mask_out =
    regs_r[trc_pkg::COLLISION_AND_IRQ_MASK_OFS[4:0]][5:0];
  assign target_id_out = id_r;
  assign ctrl = ctrl_r;
  assign full_operation = full_op_r;
  assign host_rdata = rdata_r;
  assign host_rvalid = rvalid_r;
  assign buffer_wr = buf_wr_r;
  assign buffer_rd = buf_rd_r;
  assign buffer_wdata = buf_wdata_r;

endmodule : trc_register_map

// ### trc_register_map_sva.sv
// concurrent checks on the ports of the transceiver control register map
`timescale 1ns/1ns
module trc_register_map_sva #(
  parameter int unsigned STARTUP_CYCLES = 20,
  parameter int unsigned ID_BYTES = 10
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic enable_pin, // chip enable pin
  input wire trc_pkg::trc_req_type host_req, // host request
  input wire logic [7:0] host_rdata, // read data
  input wire logic host_rvalid, // read answer strobe
  input wire trc_pkg::trc_ctrl_type ctrl, // front end levels
  input wire logic full_operation, // start-up elapsed
  input wire logic [10:0][7:0] config_out // option bytes
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rd_w;
  int unsigned act_r;
  // a write asserts too, so only a pure read is answered with data
  assign rd_w = host_req.rd && !host_req.wr;
  // cycles outside standby, saturating so it never wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) act_r <= 0;
    else if (ctrl.standby) act_r <= 0;
    else if (act_r < 100000) act_r <= act_r + 1;
  end
  // enable held high long enough that no preset lands in the window
  sequence en_s;
    enable_pin && $past(enable_pin) && $past(enable_pin, 2);
  endsequence
  sequence w0_s;
    host_req.wr && host_req.addr == 8'h00 ##0 en_s
      ##1 (enable_pin && !(host_req.wr && host_req.addr == 8'h00));
  endsequence
  a_unmapped_zero: assert property (
    rd_w && host_req.addr > 8'h1f |=> host_rvalid && host_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ident_hidden: assert property (
    rd_w && host_req.addr == 8'h17 |=> host_rvalid && host_rdata == 8'h00)
    else $error("identifier readable");
  a_reserved_zero: assert property (
    rd_w && host_req.addr == 8'h00 |=> host_rvalid && !host_rdata[2])
    else $error("reserved bit set");
  a_standby_level: assert property (
    w0_s |=> ctrl.standby == $past(host_req.wdata[7], 2))
    else $error("standby level wrong");
  a_direct_level: assert property (
    w0_s |=> ctrl.direct_mode_enable == $past(host_req.wdata[6], 2))
    else $error("direct level wrong");
  a_field_tx: assert property (
    w0_s |=> ctrl.transmitter_on == $past(host_req.wdata[5], 2))
    else $error("transmitter level wrong");
  a_forced_rx: assert property (
    w0_s |=> ctrl.receiver_on == ($past(host_req.wdata[5], 2)
      || $past(host_req.wdata[1], 2))
      && ctrl.tx_oscillator_on == ctrl.receiver_on)
    else $error("receiver enable wrong");
  a_drive_half: assert property (
    w0_s |=> ctrl.output_drive_strength_select == $past(host_req.wdata[4], 2))
    else $error("drive strength wrong");
  a_input_pick: assert property (
    w0_s |=> ctrl.receive_input_select == $past(host_req.wdata[3], 2))
    else $error("receive input wrong");
  a_supply_range: assert property (
    w0_s |=> ctrl.supply_range_select == $past(host_req.wdata[0], 2))
    else $error("supply range wrong");
  a_standby_stops: assert property (
    ctrl.standby |=> !full_operation)
    else $error("full operation in standby");
  a_startup_wait: assert property (
    $rose(full_operation) |-> act_r >= STARTUP_CYCLES)
    else $error("start-up too short");
  a_reload_defaults: assert property (
    host_req.wr && host_req.addr == 8'h01 ##0 en_s
      |=> config_out[1] == 8'h00 && config_out[10] == 8'h87)
    else $error("option defaults not reloaded");
  a_clock_kept: assert property (
    host_req.wr && host_req.addr == 8'h01 ##0 en_s
      |=> config_out[8][5:4] == $past(config_out[8][5:4]))
    else $error("clock divider bits lost");
  c_read: cover property (rd_w ##1 host_rvalid);
  c_wake: cover property ($rose(full_operation));
  c_direct_one: cover property (ctrl.direct_mode_one);
endmodule : trc_register_map_sva

bind trc_register_map trc_register_map_sva #(
  .STARTUP_CYCLES(STARTUP_CYCLES), .ID_BYTES(ID_BYTES)) u_sva (
  .clk(clk), .rst(rst), .enable_pin(enable_pin), .host_req(host_req),
  .host_rdata(host_rdata), .host_rvalid(host_rvalid), .ctrl(ctrl),
  .full_operation(full_operation), .config_out(config_out));

// ### trc_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ns
module trc_host_model (
  input wire logic clk, // system clock
  output trc_pkg::trc_req_type host_req, // register request
  input wire logic [7:0] host_rdata, // read data
  input wire logic host_rvalid, // read answer strobe
  input wire logic full_operation // start-up elapsed
);
  initial host_req = '0;
  // one write; the idle edge after it keeps strobes from colliding
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    host_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    host_req.wr <= 1'b0;
  endtask : wr
  // one read; a missing answer comes back as unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    host_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    host_req.rd <= 1'b0;
    #1 d = (host_rvalid === 1'b1) ? host_rdata : 8'hxx;
  endtask : rd
  // type bit goes in first, only then the direct bit
  task automatic direct_on(input logic [7:0] p, input logic [7:0] c);
    wr(8'h01, p);
    wr(8'h00, c | 8'h40);
  endtask : direct_on
  // leave standby and wait until the device reports full operation, for at most 1000 cycles
  task automatic wake(input logic [7:0] c, output int n);
    wr(8'h00, c & 8'h7f);
    n = 0;
    while (full_operation !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
  endtask : wake
endmodule : trc_host_model

// ### test_trc_register_map.sv
// self-checking bench for the transceiver control register map
`timescale 1ns/1ns
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin \
  failures++; $display("mismatch at %0t: %s", $time, m); end end
module test_trc_register_map;
  localparam int unsigned SC = 20;
  logic clk, rst, enable_pin, collision_update, host_rvalid, full_operation;
  logic [1:0] collision_high_in;
  logic [7:0] irq_status_in, collision_location_in, signal_level_in;
  logic [7:0] buffer_status_in, buffer_rdata_in, host_rdata, buffer_wdata;
  logic buffer_wr, buffer_rd;
  logic [5:0] irq_mask_out;
  logic [10:0][7:0] config_out;
  logic [9:0][7:0] target_id_out;
  trc_pkg::trc_req_type host_req;
  trc_pkg::trc_ctrl_type ctrl;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] ra [5] = '{8'h00, 8'h01, 8'h0a, 8'h0b, 8'h0d};
  logic [7:0] rv [5] = '{8'h01, 8'h02, 8'h10, 8'h87, 8'h3e};
  int bits [7] = '{7, 6, 5, 4, 3, 1, 0};
  trc_register_map #(.STARTUP_CYCLES(SC), .ID_BYTES(10)) dut (.clk, .rst,
    .enable_pin, .host_req, .host_rdata, .host_rvalid, .irq_status_in,
    .collision_update, .collision_high_in, .collision_location_in,
    .signal_level_in, .buffer_status_in, .buffer_rdata_in, .ctrl,
    .full_operation, .config_out, .irq_mask_out, .target_id_out,
    .buffer_wr, .buffer_rd, .buffer_wdata);
  trc_host_model h (.clk, .host_req, .host_rdata, .host_rvalid,
    .full_operation);
  // expected front end levels for a control byte and direct type bit
  function automatic trc_pkg::trc_ctrl_type exp_ctrl(logic [7:0] v, logic t);
    return '{v[7], v[6], v[6] & t, v[5], v[5] | v[1], v[5] | v[1], v[4],
      v[3], v[0]};
  endfunction : exp_ctrl
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // a hang is cut short here and reported like any mismatch
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
  initial begin
    logic [7:0] d;
    int n;
    rst = 1;
    enable_pin = 1;
    collision_update = 0;
    collision_high_in = 2'h2;
    irq_status_in = 8'ha5;
    collision_location_in = 8'h5a;
    signal_level_in = 8'h3c;
    buffer_status_in = 8'h0f;
    buffer_rdata_in = 8'h96;
    repeat (10) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    #1 `CHK(ctrl, exp_ctrl(8'h01, 1'b0), "ctrl after reset")
    foreach (ra[i]) begin
      h.rd(ra[i], d);
      `CHK(d, rv[i], "preset value")
    end
    // each control bit alone, so crossed bits show up
    foreach (bits[i]) begin
      d = 8'h01 << bits[i];
      h.wr(8'h00, d);
      @(posedge clk);
      #1 `CHK(ctrl, exp_ctrl(d, 1'b0), "ctrl")
    end
    h.wr(8'h00, 8'hff);
    h.rd(8'h00, d);
    `CHK(d, 8'hfb, "reserved bit")
    h.direct_on(8'h42, 8'h00);
    @(posedge clk);
    #1 `CHK(ctrl, exp_ctrl(8'h40, 1'b1), "direct mode one")
    h.wr(8'h09, 8'hff);
    h.wr(8'h02, 8'h55);
    h.wr(8'h0b, 8'h00);
    h.wr(8'h01, 8'h02);
    h.rd(8'h02, d);
    `CHK(d, 8'h00, "option reload")
    h.rd(8'h0b, d);
    `CHK(d, 8'h87, "regulator reload")
    h.rd(8'h09, d);
    `CHK(d, 8'h30, "clock divider kept")
    for (int i = 1; i <= 11; i++) h.wr(8'h17, 8'(i));
    `CHK(target_id_out[0], 8'h01, "first id byte")
    `CHK(target_id_out[9], 8'h0a, "tenth id byte")
    h.rd(8'h17, d);
    `CHK(d, 8'h00, "id read")
    @(posedge clk) collision_update <= 1'b1;
    @(posedge clk) collision_update <= 1'b0;
    h.wr(8'h0e, 8'h00);
    h.rd(8'h0d, d);
    `CHK(d, 8'hbe, "collision and mask")
    h.rd(8'h0e, d);
    `CHK(d, 8'h5a, "collision location")
    h.wr(8'h0d, 8'h15);
    #1 `CHK(irq_mask_out, 6'h15, "irq mask")
    h.wr(8'h1f, 8'h3c);
    #1 `CHK({buffer_wr, buffer_wdata}, 9'h13c, "buffer write")
    h.rd(8'h1f, d);
    `CHK({buffer_rd, d}, 9'h196, "buffer read")
    h.rd(8'h0c, d);
    `CHK(d, 8'ha5, "irq status")
    h.rd(8'h1c, d);
    `CHK(d, 8'h0f, "buffer status")
    h.wr(8'h20, 8'hff);
    h.rd(8'h20, d);
    `CHK(d, 8'h00, "unmapped read")
    h.rd(8'h00, d);
    `CHK(d, 8'h40, "unmapped write")
    h.wr(8'h00, 8'h81);
    repeat (2) @(posedge clk);
    #1 `CHK(full_operation, 1'b0, "standby")
    h.wake(8'h01, n);
    `CHK(n >= SC && n < 1000, 1'b1, "start-up time")
    h.wr(8'h00, 8'h21);
    @(posedge clk) enable_pin <= 1'b0;
    repeat (4) @(posedge clk);
    enable_pin <= 1'b1;
    repeat (3) @(posedge clk);
    h.rd(8'h00, d);
    `CHK(d, 8'h01, "enable preset")
    `CHK(irq_mask_out, 6'h3e, "mask preset")
    h.rd(8'h09, d);
    `CHK(d, 8'h00, "map preset")
    end_sim();
  end
endmodule : test_trc_register_map
